// ---- design/sae_params.svh ----
// Constants for the serial altitude encoder framer.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef SAE_PARAMS_SVH
`define SAE_PARAMS_SVH

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define SAE_CLK_HZ     25000000
`define SAE_BAUD_LOW   1200
`define SAE_BAUD_MID   2400
`define SAE_BAUD_HIGH  9600

// ---------------------------------------------------------------------------
// Message layout
// ---------------------------------------------------------------------------
`define SAE_LAST_LONG  5'd16
`define SAE_LAST_SHORT 5'd9
`define SAE_DIG_LONG   5'd5
`define SAE_DIG_SHORT  5'd4
`define SAE_CSUM_POS   5'd14
`define SAE_ALT_MAX    18'd99999
`define SAE_CR         8'h0D
`define SAE_ZERO       8'h30
`define SAE_FRAME_BITS 4'd9

`endif

// ---- design/sae_pkg.sv ----
// Types shared by the altitude encoder framer and its serial transmitter.
// Assumes sae_params.svh is compiled alongside.
package sae_pkg;

  // Message formats as chosen by the format selector
  typedef enum logic [1:0] {
    FMT_HASH     = 2'b00,
    FMT_DOLLAR   = 2'b01,
    FMT_ALT_SLOW = 2'b10,
    FMT_ALT_FAST = 2'b11
  } sae_fmt_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CONV  = 2'b01,
    ST_SEND  = 2'b10,
    ST_DRAIN = 2'b11
  } sae_state_t;

  typedef struct packed {
    logic [14:0] cnt;
    logic [3:0]  bit_i;
    logic [8:0]  shf;
    logic        busy;
    logic        txd;
  } sae_tx_t;

  typedef struct packed {
    sae_state_t       st;
    sae_fmt_t         fmt;
    logic             res100;
    logic [14:0]      div;
    logic             neg;
    logic [16:0]      rem;
    logic [2:0]       dpos;
    logic [4:0][3:0]  dig;
    logic [4:0]       idx;
    logic [7:0]       csum;
    logic [1:0][7:0]  mem;
    logic             wp;
    logic             rp;
    logic [1:0]       cnt;
    logic             busy;
    logic             done;
  } sae_fr_t;

endpackage

// ---- design/sae_uart_tx.sv ----
// Transmit-only 8N1 serial shifter with a run-time bit period.
// Assumes the period is held steady while a character is in flight.
`timescale 1ns/1ns
`include "sae_params.svh"
module sae_uart_tx
  import sae_pkg::*;
(
  input  wire logic        clk,      // System clock
  input  wire logic        reset,    // Synchronous reset, high
  input  wire logic [14:0] div,      // Clocks per bit
  input  wire logic        in_valid, // Character offered
  input  wire logic [7:0]  in_data,  // Character value
  output logic             in_ready, // Idle, takes a character
  output logic             txd       // Serial line, idles high
);

  sae_tx_t s_ff;
  sae_tx_t nxt_s;

  assign in_ready = !s_ff.busy;
  assign txd      = s_ff.txd;

  // ---------------------------------------------------------------------------
  // Bit timing and shifting
  // ---------------------------------------------------------------------------
  // Accepting only when idle keeps the stop bit whole before the next start
  always_comb begin
    nxt_s = s_ff;
    if (!s_ff.busy) begin
      if (in_valid) begin
        nxt_s.busy  = 1'b1;
        nxt_s.txd   = 1'b0;               // Start bit
        nxt_s.shf   = {1'b1, in_data};    // Data then stop, LSB first
        nxt_s.bit_i = 4'd0;
        nxt_s.cnt   = div - 15'd1;
      end
    end else if (s_ff.cnt != 15'd0) begin
      nxt_s.cnt = s_ff.cnt - 15'd1;
    end else if (s_ff.bit_i == `SAE_FRAME_BITS) begin
      nxt_s.busy = 1'b0;
    end else begin
      nxt_s.txd   = s_ff.shf[0];
      nxt_s.shf   = {1'b1, s_ff.shf[8:1]};
      nxt_s.bit_i = s_ff.bit_i + 4'd1;
      nxt_s.cnt   = div - 15'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_ff <= '{cnt: 15'h0000, bit_i: 4'h0, shf: 9'h1FF,
                busy: 1'b0, txd: 1'b1};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_start_low: assert property (@(posedge clk) disable iff (reset)
    in_valid && in_ready |=> !txd && !in_ready)
    else $error("start bit not driven low");

endmodule

// ---- design/sae_framer.sv ----
// Serial altitude encoder framer: builds one message per request.
// Assumes the altitude input is pressure altitude in feet, two's complement,
// steady in the cycle of the request; line is 8N1.
//
// Functional notes
// - Selector picks one of four formats
// - Altitude quantised to 10 or 100 feet
// - Format one: #AL, sign, digits, T+25, sum
// - Format two: $MGL, sign, digits, T+25, sum
// - Formats three, four: ALT digits, 2400/9600
// - Reported altitude is pressure altitude only
`timescale 1ns/1ns
`include "sae_params.svh"
module sae_framer
  import sae_pkg::*;
#(
  parameter int DIV_LOW = (`SAE_CLK_HZ + `SAE_BAUD_LOW / 2) / `SAE_BAUD_LOW,
  parameter int DIV_MID = (`SAE_CLK_HZ + `SAE_BAUD_MID / 2) / `SAE_BAUD_MID
)
(
  input  wire logic        clk,          // System clock, 25 MHz
  input  wire logic        reset,        // Synchronous reset, high
  input  wire logic        msg_start,    // Pulse: send one message
  input  wire logic [1:0]  msg_fmt_sel,  // Message format selector
  input  wire logic        res_100,      // 1: 100 ft steps, 0: 10 ft
  input  wire logic [17:0] press_alt_ft, // Pressure altitude, signed
  output logic             txd,          // Encoder serial transmit
  output logic             busy,         // Message in progress
  output logic             msg_done      // Pulse: message fully sent
);

  localparam int DIV_HIGH = (`SAE_CLK_HZ + `SAE_BAUD_HIGH / 2)
                            / `SAE_BAUD_HIGH;

  sae_fr_t     s_ff;
  sae_fr_t     nxt_s;
  logic        push;
  logic        pop;
  logic        tx_ready;
  logic [7:0]  push_chr;
  logic [17:0] mag;
  logic [16:0] pw;

  assign busy     = s_ff.busy;
  assign msg_done = s_ff.done;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [16:0] pow10(input logic [2:0] p);
    case (p)
      3'd0:    pow10 = 17'd10000;
      3'd1:    pow10 = 17'd1000;
      3'd2:    pow10 = 17'd100;
      3'd3:    pow10 = 17'd10;
      default: pow10 = 17'd1;
    endcase
  endfunction

  function automatic logic [7:0] hex(input logic [3:0] v);
    hex = (v < 4'hA) ? {4'h3, v} : 8'(8'h37 + {4'h0, v});
  endfunction

  // Digit character, with the low digits forced to zero by resolution
  function automatic logic [7:0] dchr(input sae_fr_t s, input logic [4:0] d);
    logic [2:0] k;
    k = d[2:0];
    if (k == 3'd4 || (k == 3'd3 && s.res100)) begin
      dchr = `SAE_ZERO;
    end else begin
      dchr = {4'h3, s.dig[k]};
    end
  endfunction

  // Character at the current message position
  function automatic logic [7:0] char_at(input sae_fr_t s);
    logic h;
    h = (s.fmt == FMT_HASH);
    char_at = `SAE_CR;
    if (s.fmt == FMT_HASH || s.fmt == FMT_DOLLAR) begin
      case (s.idx)
        5'd0:  char_at = h ? 8'h23 : 8'h24;
        5'd1:  char_at = h ? 8'h41 : 8'h4D;
        5'd2:  char_at = h ? 8'h4C : 8'h47;
        5'd3:  char_at = h ? 8'h20 : 8'h4C;     // Space in format one, L in format two
        5'd4:  char_at = s.neg ? 8'h2D : 8'h2B; // Sign
        5'd5, 5'd6, 5'd7, 5'd8, 5'd9:
               char_at = dchr(s, s.idx - `SAE_DIG_LONG);
        5'd10: char_at = 8'h54;                 // T+25
        5'd11: char_at = 8'h2B;
        5'd12: char_at = 8'h32;
        5'd13: char_at = 8'h35;
        5'd14: char_at = hex(s.csum[7:4]);
        5'd15: char_at = hex(s.csum[3:0]);
        default: char_at = `SAE_CR;
      endcase
    end else begin
      case (s.idx)
        5'd0:  char_at = 8'h41;
        5'd1:  char_at = 8'h4C;
        5'd2:  char_at = 8'h54;
        5'd3:  char_at = 8'h20;
        5'd4, 5'd5, 5'd6, 5'd7, 5'd8:
               char_at = dchr(s, s.idx - `SAE_DIG_SHORT);
        default: char_at = `SAE_CR;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Sequencing, conversion and the two-entry buffer
  // ---------------------------------------------------------------------------
  // The buffer lets the shifter stall character pushes without losing one
  assign push     = (s_ff.st == ST_SEND) && (s_ff.cnt != 2'd2);
  assign pop      = (s_ff.cnt != 2'd0) && tx_ready;
  assign push_chr = char_at(s_ff);
  assign pw       = pow10(s_ff.dpos);
  assign mag      = press_alt_ft[17] ? 18'(-press_alt_ft) : press_alt_ft;

  always_comb begin
    nxt_s      = s_ff;
    nxt_s.done = 1'b0;
    unique case (s_ff.st)
      ST_IDLE: begin
        if (msg_start) begin
          nxt_s.st     = ST_CONV;
          nxt_s.fmt    = sae_fmt_t'(msg_fmt_sel);
          nxt_s.res100 = res_100;
          unique case (sae_fmt_t'(msg_fmt_sel))
            FMT_HASH, FMT_DOLLAR: nxt_s.div = 15'(DIV_LOW);
            FMT_ALT_SLOW:         nxt_s.div = 15'(DIV_MID);
            FMT_ALT_FAST:         nxt_s.div = 15'(DIV_HIGH);
          endcase
          // Baro setting never enters: input is already 29.92 based
          nxt_s.neg  = press_alt_ft[17];
          nxt_s.rem  = (mag > `SAE_ALT_MAX) ? 17'(`SAE_ALT_MAX)
                                            : mag[16:0];
          nxt_s.dpos = 3'd0;
          nxt_s.dig  = '0;
          nxt_s.busy = 1'b1;
        end
      end
      ST_CONV: begin
        // Repeated subtraction: slow but tiny, up to 50 cycles per message
        if (s_ff.rem >= pw) begin
          nxt_s.rem              = s_ff.rem - pw;
          nxt_s.dig[s_ff.dpos]   = s_ff.dig[s_ff.dpos] + 4'd1;
        end else if (s_ff.dpos == 3'd4) begin
          nxt_s.st   = ST_SEND;
          nxt_s.idx  = 5'd0;
          nxt_s.csum = 8'h00;
        end else begin
          nxt_s.dpos = s_ff.dpos + 3'd1;
        end
      end
      ST_SEND: begin
        if (push) begin
          nxt_s.mem[s_ff.wp] = push_chr;
          nxt_s.wp           = !s_ff.wp;
          nxt_s.idx          = s_ff.idx + 5'd1;
          if (s_ff.idx < `SAE_CSUM_POS) begin
            nxt_s.csum = s_ff.csum + push_chr;
          end
          if (s_ff.idx == ((s_ff.fmt[1]) ? `SAE_LAST_SHORT
                                          : `SAE_LAST_LONG)) begin
            nxt_s.st = ST_DRAIN;
          end
        end
      end
      ST_DRAIN: begin
        // Period may only change once the last stop bit is out
        if (s_ff.cnt == 2'd0 && tx_ready) begin
          nxt_s.st   = ST_IDLE;
          nxt_s.busy = 1'b0;
          nxt_s.done = 1'b1;
        end
      end
    endcase
    if (pop) begin
      nxt_s.rp = !s_ff.rp;
    end
    nxt_s.cnt = s_ff.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ---------------------------------------------------------------------------
  // Serial shifter
  // ---------------------------------------------------------------------------
  sae_uart_tx u_tx (
    .clk      (clk),
    .reset    (reset),
    .div      (s_ff.div),
    .in_valid (s_ff.cnt != 2'd0),
    .in_data  (s_ff.mem[s_ff.rp]),
    .in_ready (tx_ready),
    .txd      (txd)
  );

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_fmt_stable: assert property (s_ff.st != ST_IDLE |=>
    s_ff.st == ST_IDLE || $stable(s_ff.fmt))
    else $error("format changed inside a message");
  a_res_units: assert property (push && s_ff.fmt[1] &&
    s_ff.idx == 5'd8 |-> push_chr == `SAE_ZERO)
    else $error("units digit not zero");
  a_res_tens: assert property (push && !s_ff.fmt[1] && s_ff.res100 &&
    s_ff.idx == 5'd8 |-> push_chr == `SAE_ZERO)
    else $error("tens digit not zero at 100 ft");
  a_baud_low: assert property (s_ff.st == ST_SEND &&
    !s_ff.fmt[1] |-> s_ff.div == 15'(DIV_LOW))
    else $error("wrong bit period for formats one and two");
  a_hdr_dollar: assert property (push && s_ff.idx == 5'd0 &&
    s_ff.fmt == FMT_DOLLAR |-> push_chr == 8'h24 ##1 push_chr == 8'h4D)
    else $error("format two header wrong");
  a_baud_fast: assert property (s_ff.st == ST_SEND &&
    s_ff.fmt == FMT_ALT_FAST |-> s_ff.div == 15'(DIV_HIGH))
    else $error("wrong bit period for format four");
  a_baud_mid: assert property (s_ff.st == ST_SEND &&
    s_ff.fmt == FMT_ALT_SLOW |-> s_ff.div == 15'(DIV_MID))
    else $error("wrong bit period for format three");
  a_cr_last: assert property (push && s_ff.fmt[1] &&
    s_ff.idx == `SAE_LAST_SHORT |-> push_chr == `SAE_CR ##1
    s_ff.st == ST_DRAIN)
    else $error("short message not ended by carriage return");
  a_sign_latch: assert property (s_ff.st == ST_IDLE && msg_start |=>
    s_ff.st == ST_CONV && s_ff.neg == $past(press_alt_ft[17]))
    else $error("sign not taken from altitude input");
  a_csum_hex: assert property (push && !s_ff.fmt[1] &&
    s_ff.idx == `SAE_CSUM_POS |-> (push_chr inside {[8'h30:8'h39],
    [8'h41:8'h46]}))
    else $error("checksum not an upper-case hex character");
  a_conv_bound: assert property (s_ff.st == ST_IDLE && msg_start |->
    ##[1:60] s_ff.st == ST_SEND)
    else $error("conversion too slow");

  c_fmt_hash: cover property (s_ff.done && s_ff.fmt == FMT_HASH);
  c_fmt_fast: cover property (s_ff.done && s_ff.fmt == FMT_ALT_FAST);
  c_negative: cover property (push && s_ff.neg && s_ff.idx == 5'd4);
  c_buf_full: cover property (s_ff.cnt == 2'd2);

endmodule

// ---- tb/sae_rx_model.sv ----
// Behavioural 8N1 receiver standing where the transponder input would be.
// Assumes txd idles high and the bench sets div to the bit period in clocks.
`timescale 1ns/1ns
module sae_rx_model (
  input  wire logic        clk,       // System clock
  input  wire logic        reset,     // Synchronous reset, high
  input  wire logic        txd,       // Line from the framer
  input  wire logic [14:0] div,       // Clocks per bit
  output logic [7:0]       rx_byte,   // Last character taken
  output logic             rx_stb,    // One-cycle pulse per character
  output logic             frame_err  // Sticky start or stop bit fault
);
  logic [7:0] shf;
  initial begin
    rx_byte   = 8'h00;
    rx_stb    = 1'b0;
    frame_err = 1'b0;
  end
  // Mid-bit sampling; a wrong baud garbles the bytes instead of passing
  always begin
    @(posedge clk);
    rx_stb <= 1'b0;
    if (!reset && txd === 1'b0) begin
      repeat (div / 2) @(posedge clk);
      if (txd !== 1'b0) frame_err <= 1'b1;
      for (int i = 0; i < 8; i++) begin
        repeat (div) @(posedge clk);
        shf[i] = txd; // LSB first
      end
      repeat (div) @(posedge clk);
      if (txd !== 1'b1) frame_err <= 1'b1;
      rx_byte <= shf;
      rx_stb  <= 1'b1;
    end
  end
endmodule

// ---- tb/sae_framer_tb.sv ----
// Self-checking bench for the altitude encoder framer.
// Assumes short divisors for the two slower rates; the fast one is fixed.
`timescale 1ns/1ns
module sae_framer_tb;
  localparam int DLO = 16;
  localparam int DMI = 8;
  localparam int DHI = 2604;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        msg_start = 1'b0;
  logic [1:0]  msg_fmt_sel = 2'b00;
  logic        res_100 = 1'b0;
  logic [17:0] press_alt_ft = 18'h00000;
  logic [14:0] rx_div = 15'h0010;
  logic        txd, busy, msg_done, rx_stb, frame_err;
  logic [7:0]  rx_byte;
  logic [7:0]  exp_q[$];
  logic [7:0]  rx_q[$];
  int          fails = 0;
  int          checks_done = 0;

  always #20 clk = ~clk;

  sae_framer #(.DIV_LOW(DLO), .DIV_MID(DMI)) dut_u (
    .clk(clk), .reset(reset), .msg_start(msg_start),
    .msg_fmt_sel(msg_fmt_sel), .res_100(res_100),
    .press_alt_ft(press_alt_ft), .txd(txd), .busy(busy),
    .msg_done(msg_done));
  sae_rx_model rx_u (
    .clk(clk), .reset(reset), .txd(txd), .div(rx_div),
    .rx_byte(rx_byte), .rx_stb(rx_stb), .frame_err(frame_err));

  // Collect every character the receiver hands over
  always @(posedge clk) if (rx_stb) rx_q.push_back(rx_byte);

  task automatic check(input logic [31:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask

  task automatic end_sim;
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 10) ? 8'(n + 48) : 8'(n + 55);
  endfunction

  // Expected message worked out independently of the design
  task automatic build(input int f, input int r, input int a);
    int m;
    logic [7:0] s;
    m = (a < 0) ? -a : a;
    if (m > 99999) m = 99999;
    m = r ? m / 100 * 100 : m / 10 * 10;
    if (f == 0) exp_q = {8'h23, 8'h41, 8'h4C, 8'h20};
    else if (f == 1) exp_q = {8'h24, 8'h4D, 8'h47, 8'h4C};
    else exp_q = {8'h41, 8'h4C, 8'h54, 8'h20};
    if (f < 2) exp_q.push_back((a < 0) ? 8'h2D : 8'h2B);
    for (int d = 10000; d > 0; d /= 10) exp_q.push_back(8'((m / d) % 10 + 48));
    if (f < 2) begin
      exp_q = {exp_q, 8'h54, 8'h2B, 8'h32, 8'h35};
      s = 8'h00;
      foreach (exp_q[i]) s += exp_q[i];
      exp_q.push_back(hexc(s[7:4]));
      exp_q.push_back(hexc(s[3:0]));
    end
    exp_q.push_back(8'h0D);
  endtask

  task automatic start(input int f, input int r, input int a);
    build(f, r, a);
    @(negedge clk);
    msg_fmt_sel  = 2'(f);
    res_100      = r[0];
    press_alt_ft = 18'(a);
    rx_div       = 15'((f < 2) ? DLO : (f == 2) ? DMI : DHI);
    msg_start    = 1'b1;
    rx_q         = {};
    @(negedge clk);
    msg_start = 1'b0;
    check(busy, 1, "busy not raised");
  endtask

  task automatic finish_msg(input string what);
    int n;
    n = 0;
    while (msg_done !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 20000) begin
        fails++;
        end_sim;
      end
    end
    check(busy, 0, "busy after done");
    check(rx_q.size(), exp_q.size(), what);
    foreach (exp_q[i])
      if (i < rx_q.size()) check(rx_q[i], exp_q[i], what);
    check(frame_err, 0, "line framing");
    @(negedge clk);
    check(msg_done, 0, "done longer than one cycle");
  endtask

  // Format one; a second request while busy must be ignored
  task automatic t_hash_refuse;
    start(0, 0, 5234);
    repeat (20) @(negedge clk);
    msg_fmt_sel = 2'b10;
    msg_start   = 1'b1;
    @(negedge clk);
    msg_start = 1'b0;
    finish_msg("hash message");
  endtask

  // Format two, negative, 100 ft steps, started right after done
  task automatic t_dollar_neg;
    start(1, 1, -1234);
    finish_msg("dollar message");
  endtask

  // Format three with a clamped altitude
  task automatic t_alt_clamp;
    start(2, 0, 123456);
    finish_msg("alt clamp");
  endtask

  // Zero at 100 ft, a small negative value at 10 ft, format three at 100 ft
  task automatic t_small;
    start(0, 1, 0);
    finish_msg("zero altitude");
    start(1, 0, -7);
    finish_msg("small negative");
    start(2, 1, 5299);
    finish_msg("alt 100 ft");
  endtask

  // Format four: first character at 9600 baud, abort by reset, then recover
  task automatic t_fast_abort;
    int n;
    start(3, 0, 5200);
    n = 0;
    while (rx_q.size() == 0 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40000) begin
      fails++;
      end_sim;
    end
    check(rx_q.size(), 1, "fast first char missing");
    if (rx_q.size() > 0) check(rx_q[0], 8'h41, "fast first char");
    reset = 1'b1;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    check(txd, 1, "line idle after reset");
    check(busy, 0, "busy after reset");
    start(2, 0, 400);
    finish_msg("message after reset");
  endtask

  initial begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    t_hash_refuse();
    t_dollar_neg();
    t_alt_clamp();
    t_small();
    t_fast_abort();
    end_sim();
  end
endmodule
